/* File: hw/dqvref_pkg.sv */
// ****************************************************************
// Constants for the DQ reference mode register.
// ****************************************************************
package dqvref_pkg;

    // ****************************************************************
    // Address and field layout.
    // ****************************************************************
    localparam logic [5:0] DQVREF_ADDR      = 6'h0e;
    localparam int         DQVREF_LEVEL_LSB = 0;
    localparam int         DQVREF_LEVEL_W   = 6;
    localparam int         DQVREF_RANGE_BIT = 6;
    localparam int         DQVREF_RSVD_BIT  = 7;

    // ****************************************************************
    // Legal codes and values after reset.
    // ****************************************************************
    localparam logic [5:0] DQVREF_LEVEL_MAX = 6'h32;
    localparam logic [5:0] DQVREF_LEVEL_RST = 6'h1d;
    localparam logic       DQVREF_RANGE_RST = 1'b1;
    localparam logic [7:0] DQVREF_DQ_IDLE   = 8'h00;

    // ****************************************************************
    // Timing and structure.
    // ****************************************************************
    localparam int         DQVREF_RD_LATENCY_CYC = 2;
    localparam int         DQVREF_NUM_SP         = 2;
    localparam logic [7:0] DQVREF_CNT_ONE        = 8'h01;

    // ****************************************************************
    // Carriers and states.
    // ****************************************************************
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] op;
    } dqvref_cmd_type;

    typedef struct packed {
        logic       range;
        logic [5:0] level;
    } dqvref_set_type;

    typedef enum logic [1:0] {
        DQVREF_IDLE  = 2'b00,
        DQVREF_WAIT  = 2'b01,
        DQVREF_DRIVE = 2'b11
    } dqvref_state_type;

endpackage : dqvref_pkg

/* File: hw/dqvref_setpoint.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// One physical copy of the register for one set point.
// ****************************************************************
module dqvref_setpoint (
    // Clock, reset, enable
    input  wire logic                    clk_in,
    input  wire logic                    rst_b_in,
    input  wire logic                    ce_in,
    // Write port
    input  wire logic                    wr_en_in,
    input  wire dqvref_pkg::dqvref_set_type wr_data_in,
    // Stored copy
    output var  dqvref_pkg::dqvref_set_type sp_out
);

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sp_out <= '{range: dqvref_pkg::DQVREF_RANGE_RST, level: dqvref_pkg::DQVREF_LEVEL_RST};
        end else if (ce_in && wr_en_in) begin
            sp_out <= wr_data_in; // see [RQ7]
        end
    end

endmodule : dqvref_setpoint

`default_nettype wire

/* File: hw/dqvref_top.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// DQ reference mode register with two frequency set points.
// ****************************************************************

// Contract
// [RQ1] Level codes 0 to 0x32 are legal, higher reserved; default level 0x1d.
// [RQ2] Bit 6 picks range: zero lower, one upper; upper after reset.
// [RQ3] A read of this address returns the eight register bits on data 7..0.
// [RQ4] Reserved bit 7 and unused data lines read as zero.
// [RQ5] Level write goes to copy 0 or 1 per the write-select bit.
// [RQ6] Controller always supplies the range bit alongside the level code.
// [RQ7] Stored values hold until overwritten or until reset.
// [RQ8] Two copies exist; writes and reads reach only the write-selected one.
// [RQ9] Operating settings come only from the operate-selected copy.
// [RQ10] The inactive copy is ignored and may be rewritten freely.
// [RQ11] Controller may switch settings by toggling operate-select alone.
// [RQ12] Writes with a reserved level code are undefined and flagged.
module dqvref_top #(
    parameter int RD_LATENCY = dqvref_pkg::DQVREF_RD_LATENCY_CYC
) (
    // Clock, reset, enable
    input  wire logic                       core_clk_in,
    input  wire logic                       rst_b_in,
    input  wire logic                       ce_in,
    // Mode register command
    input  wire dqvref_pkg::dqvref_cmd_type cmd_in,
    // Set point selects from the set point control register
    input  wire logic                       setpoint_write_select_in,
    input  wire logic                       setpoint_operate_select_in,
    // Read data lines
    output logic [7:0]                      dq_out,
    output logic                            dq_oe_out,
    output logic                            rd_busy_out,
    // Operating reference setting
    output logic [5:0]                      dq_reference_level_out,
    output logic                            dq_reference_range_out,
    // Reserved code write flag
    output logic                            reserved_write_out
);

    // ****************************************************************
    // Elaboration checks.
    // ****************************************************************
    if (RD_LATENCY < 1 || RD_LATENCY > 255) begin : g_bad_latency
        $error("RD_LATENCY must lie between 1 and 255");
    end

    // The selects are single bits, so exactly two copies can ever be reached.
    if (dqvref_pkg::DQVREF_NUM_SP != 2) begin : g_bad_copies
        $error("DQVREF_NUM_SP must be 2");
    end

    // The stored word packs range above level and must leave the reserved bit free.
    if (dqvref_pkg::DQVREF_LEVEL_LSB != 0 || dqvref_pkg::DQVREF_LEVEL_W != 6
        || dqvref_pkg::DQVREF_RANGE_BIT != 6
        || dqvref_pkg::DQVREF_RSVD_BIT != 7) begin : g_bad_layout
        $error("register field layout does not match the stored word");
    end

    localparam logic [7:0] LAT_LOAD = 8'(RD_LATENCY - 1);

    // ****************************************************************
    // Command field split.
    // ****************************************************************
    wire logic [5:0] op_level_w;
    wire logic       op_range_w;

    // Bit 7 of the operand is reserved and is deliberately left undecoded.
    assign op_level_w = cmd_in.op[dqvref_pkg::DQVREF_LEVEL_LSB +: dqvref_pkg::DQVREF_LEVEL_W];
    assign op_range_w = cmd_in.op[dqvref_pkg::DQVREF_RANGE_BIT];

    // ****************************************************************
    // Command decode.
    // ****************************************************************
    dqvref_pkg::dqvref_state_type state_reg;
    dqvref_pkg::dqvref_state_type state_next;
    logic [7:0]                   cnt_reg;
    logic [7:0]                   cnt_next;
    logic [7:0]                   snap_reg;
    logic [7:0]                   snap_next;

    wire logic addr_hit_w;
    wire logic wr_take_w;
    wire logic level_ok_w;
    wire logic wr_commit_w;
    wire logic rsv_write_w;
    wire logic rd_take_w;

    assign addr_hit_w  = (cmd_in.addr == dqvref_pkg::DQVREF_ADDR);
    assign wr_take_w   = cmd_in.wr && addr_hit_w;
    assign level_ok_w  = (op_level_w <= dqvref_pkg::DQVREF_LEVEL_MAX); // see [RQ1]
    // A reserved code is dropped rather than stored, so the analog side never sees it.
    assign wr_commit_w = wr_take_w && level_ok_w; // see [RQ12]
    assign rsv_write_w = wr_take_w && !level_ok_w; // see [RQ12]
    // A read is refused while an earlier answer is still pending or when a write shares the cycle.
    assign rd_take_w   = cmd_in.rd && !cmd_in.wr && addr_hit_w
                         && (state_reg == dqvref_pkg::DQVREF_IDLE);

    // ****************************************************************
    // Set point copies.
    // ****************************************************************
    dqvref_pkg::dqvref_set_type sp_q[dqvref_pkg::DQVREF_NUM_SP];
    dqvref_pkg::dqvref_set_type wr_data_w;

    // The range bit is always taken from the command itself, never kept from before.
    assign wr_data_w = '{range: op_range_w, level: op_level_w}; // see [RQ2] see [RQ6]

    for (genvar g = 0; g < dqvref_pkg::DQVREF_NUM_SP; g++) begin : g_sp
        wire logic wr_en_w;
        // Only the write-selected copy is touched; the other keeps its value.
        assign wr_en_w = wr_commit_w && (setpoint_write_select_in == 1'(g)); // see [RQ5] see [RQ8]
        dqvref_setpoint u_sp (
            .clk_in     (core_clk_in),
            .rst_b_in   (rst_b_in),
            .ce_in      (ce_in),
            .wr_en_in   (wr_en_w),
            .wr_data_in (wr_data_w),
            .sp_out     (sp_q[g])
        );
    end

    // ****************************************************************
    // Copy selection.
    // ****************************************************************
    dqvref_pkg::dqvref_set_type rd_copy_w;
    dqvref_pkg::dqvref_set_type op_copy_w;
    wire logic [7:0]            rd_word_w;

    assign rd_copy_w = sp_q[setpoint_write_select_in]; // see [RQ8]
    // Writes to the inactive copy cannot reach the operating outputs through this path.
    assign op_copy_w = sp_q[setpoint_operate_select_in]; // see [RQ9] see [RQ10]
    // The reserved top bit is never stored, so it is rebuilt as a constant zero.
    assign rd_word_w = {1'b0, rd_copy_w.range, rd_copy_w.level}; // see [RQ3] see [RQ4]

    // ****************************************************************
    // Read answer sequencer.
    // ****************************************************************
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        // The answer is captured at the take edge, so a later write cannot alter it.
        snap_next  = rd_take_w ? rd_word_w : snap_reg;
        case (state_reg)
            dqvref_pkg::DQVREF_IDLE: begin
                if (rd_take_w) begin
                    if (RD_LATENCY == 1) begin
                        state_next = dqvref_pkg::DQVREF_DRIVE;
                    end else begin
                        state_next = dqvref_pkg::DQVREF_WAIT;
                        cnt_next   = LAT_LOAD;
                    end
                end
            end
            dqvref_pkg::DQVREF_WAIT: begin
                if (cnt_reg == dqvref_pkg::DQVREF_CNT_ONE) begin
                    state_next = dqvref_pkg::DQVREF_DRIVE;
                end else begin
                    cnt_next = cnt_reg - dqvref_pkg::DQVREF_CNT_ONE;
                end
            end
            dqvref_pkg::DQVREF_DRIVE: begin
                state_next = dqvref_pkg::DQVREF_IDLE;
            end
            default: begin
                state_next = dqvref_pkg::DQVREF_IDLE;
            end
        endcase
    end

    wire logic       drive_next_w;
    wire logic [7:0] dq_next_w;

    assign drive_next_w = (state_next == dqvref_pkg::DQVREF_DRIVE);
    // Lines read as zero whenever no answer is being driven.
    assign dq_next_w    = drive_next_w ? snap_next : dqvref_pkg::DQVREF_DQ_IDLE; // see [RQ4]

    // ****************************************************************
    // State and output flops.
    // ****************************************************************
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_reg <= dqvref_pkg::DQVREF_IDLE;
            cnt_reg   <= '0;
            snap_reg  <= dqvref_pkg::DQVREF_DQ_IDLE;
        end else if (ce_in) begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            snap_reg  <= snap_next;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            dq_out      <= dqvref_pkg::DQVREF_DQ_IDLE;
            dq_oe_out   <= 1'b0;
            rd_busy_out <= 1'b0;
        end else if (ce_in) begin
            dq_out      <= dq_next_w; // see [RQ3]
            dq_oe_out   <= drive_next_w;
            // Busy spans the wait and drive cycles so the controller can pace its reads.
            rd_busy_out <= (state_next != dqvref_pkg::DQVREF_IDLE);
        end
    end

    // The operating setting lags a select or copy change by one cycle.
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            dq_reference_level_out <= dqvref_pkg::DQVREF_LEVEL_RST; // see [RQ1]
            dq_reference_range_out <= dqvref_pkg::DQVREF_RANGE_RST; // see [RQ2]
            reserved_write_out     <= 1'b0;
        end else if (ce_in) begin
            dq_reference_level_out <= op_copy_w.level; // see [RQ9]
            dq_reference_range_out <= op_copy_w.range; // see [RQ9]
            reserved_write_out     <= rsv_write_w; // see [RQ12]
        end
    end

endmodule : dqvref_top

`default_nettype wire

/* File: sim/dqvref_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Port checks for the DQ reference register.
// ****************************************************************
module dqvref_asserts #(
    parameter int RD_LATENCY = dqvref_pkg::DQVREF_RD_LATENCY_CYC
) (
    // Clock, reset, command side
    input wire logic                       core_clk_in,
    input wire logic                       rst_b_in,
    input wire logic                       ce_in,
    input wire dqvref_pkg::dqvref_cmd_type cmd_in,
    input wire logic                       setpoint_write_select_in,
    input wire logic                       setpoint_operate_select_in,
    // Device answers
    input wire logic [7:0]                 dq_out,
    input wire logic                       dq_oe_out,
    input wire logic                       rd_busy_out,
    input wire logic [5:0]                 dq_reference_level_out,
    input wire logic                       dq_reference_range_out,
    input wire logic                       reserved_write_out
);
    wire logic       hit    = cmd_in.addr == dqvref_pkg::DQVREF_ADDR;
    wire logic       bad    = cmd_in.op[5:0] > dqvref_pkg::DQVREF_LEVEL_MAX;
    wire logic       same   = setpoint_write_select_in == setpoint_operate_select_in;
    wire logic       rsv_rq = ce_in && cmd_in.wr && hit && bad;
    wire logic       rd_rq  = ce_in && cmd_in.rd && !cmd_in.wr && hit && !rd_busy_out;
    wire logic [6:0] wr_val = cmd_in.op[6:0];
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);

    a_rsv_flag_set: assert property (rsv_rq |=> reserved_write_out)
        else $error("reserved write not flagged");
    a_rsv_flag_cause: assert property (reserved_write_out |-> $past(rsv_rq))
        else $error("flag without reserved write");
    a_dq_idle_zero: assert property (!dq_oe_out
        |-> dq_out == dqvref_pkg::DQVREF_DQ_IDLE) else $error("data lines not zero when idle");
    a_dq_bit_seven: assert property (dq_oe_out |-> !dq_out[7])
        else $error("reserved bit read as one");
    a_read_answer: assert property (rd_rq |-> ##RD_LATENCY dq_oe_out)
        else $error("read answer late or missing");
    a_read_busy: assert property (rd_rq |=> rd_busy_out[*2])
        else $error("busy not raised by read");
    a_oe_single: assert property (dq_oe_out |=> !dq_oe_out)
        else $error("answer longer than one cycle");
    a_reset_default: assert property ($rose(rst_b_in)
        |-> dq_reference_range_out
        && dq_reference_level_out == dqvref_pkg::DQVREF_LEVEL_RST) else $error("bad reset value");
    a_hold_outputs: assert property (
        (ce_in && !(cmd_in.wr && hit && same)) ##1
        (ce_in && $stable(setpoint_operate_select_in)) |=> $stable(dq_reference_level_out)
        && $stable(dq_reference_range_out)) else $error("operating value moved");
    a_write_active: assert property (
        (ce_in && cmd_in.wr && hit && !bad && same) ##1
        (ce_in && $stable(setpoint_operate_select_in)) |=> {dq_reference_range_out,
        dq_reference_level_out} == $past(wr_val, 2)) else $error("active write not applied");
endmodule : dqvref_asserts

bind dqvref_top dqvref_asserts #(.RD_LATENCY(RD_LATENCY)) u_asserts (
    .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in), .cmd_in(cmd_in),
    .setpoint_write_select_in(setpoint_write_select_in), .dq_out(dq_out),
    .setpoint_operate_select_in(setpoint_operate_select_in), .dq_oe_out(dq_oe_out),
    .rd_busy_out(rd_busy_out), .dq_reference_level_out(dq_reference_level_out),
    .dq_reference_range_out(dq_reference_range_out), .reserved_write_out(reserved_write_out));
`default_nettype wire

/* File: sim/dqvref_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Memory controller issuing mode register commands.
// ****************************************************************
module dqvref_ctrl_model (
    // Clock
    input  wire logic                      clk_in,
    // Command and set point selects
    output var dqvref_pkg::dqvref_cmd_type cmd_out,
    output var logic                       wsel_out,
    output var logic                       osel_out
);
    initial cmd_out = '0;
    initial wsel_out = 1'h0;
    initial osel_out = 1'h0;
    // Idle cycles show inverted address and data so no stale value looks valid.
    task automatic issue(input logic wr, rd, input logic [5:0] a, input logic [7:0] op,
                         input logic w, o);
        @(negedge clk_in);
        cmd_out = '{wr, rd, a, op};
        wsel_out = w;
        osel_out = o;
        @(negedge clk_in);
        cmd_out = '{1'h0, 1'h0, ~a, ~op};
    endtask : issue
endmodule : dqvref_ctrl_model
`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Random and corner traffic against the DQ reference register.
// ****************************************************************
module testbench;
    localparam int         LAT  = 2;
    localparam logic [5:0] ADDR = dqvref_pkg::DQVREF_ADDR;
    logic                       core_clk_in, rst_b_in, ce_in, wsel, osel, oe, busy, rng, rsv;
    logic                       w, o;
    logic [5:0]                 lvl, lv;
    logic [7:0]                 dq;
    logic [6:0]                 sh [2];
    dqvref_pkg::dqvref_cmd_type cmd;
    int                         mismatches, compares, seed = 56;
    logic [5:0]                 corner [4] = '{6'h00, 6'h32, 6'h33, 6'h3f};

    dqvref_top #(.RD_LATENCY(LAT)) u_dut (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
        .ce_in(ce_in), .cmd_in(cmd), .setpoint_write_select_in(wsel), .dq_out(dq),
        .setpoint_operate_select_in(osel), .dq_oe_out(oe), .rd_busy_out(busy),
        .dq_reference_level_out(lvl), .dq_reference_range_out(rng), .reserved_write_out(rsv));
    dqvref_ctrl_model u_ctrl (.clk_in(core_clk_in), .cmd_out(cmd), .wsel_out(wsel),
        .osel_out(osel));

    function automatic logic legal(input logic [5:0] v);
        return v <= dqvref_pkg::DQVREF_LEVEL_MAX;
    endfunction : legal
    task automatic chk(input logic [7:0] got, exp, input string what);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic finish_test();
        if (mismatches == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : finish_test
    task automatic do_reset();
        rst_b_in = 1'h0;
        repeat (5) @(negedge core_clk_in);
        rst_b_in = 1'h1;
        sh[0] = {dqvref_pkg::DQVREF_RANGE_RST, dqvref_pkg::DQVREF_LEVEL_RST};
        sh[1] = sh[0];
        chk(8'({rng, lvl}), 8'(sh[0]), "default");
    endtask : do_reset
    task automatic do_write(input logic [5:0] v, input logic r, w, o);
        // A random read bit rides along; the write must win and no answer may follow.
        u_ctrl.issue(1'h1, 1'($random(seed)), ADDR, {1'($random(seed)), r, v}, w, o);
        if (legal(v)) sh[w] = {r, v};
        chk(8'(rsv), 8'(!legal(v)), "flag");
        @(negedge core_clk_in);
        chk(8'({rng, lvl}), 8'(sh[o]), "oper");
        chk(8'(oe), 8'h00, "write wins");
    endtask : do_write
    task automatic do_read(input logic [5:0] a, input logic w, o);
        int n;
        u_ctrl.issue(1'h0, 1'h1, a, 8'($random(seed)), w, o);
        n = 0;
        while (oe !== 1'h1 && n < LAT + 2) begin
            @(negedge core_clk_in);
            n++;
        end
        if (a == ADDR) begin
            chk(8'(n), 8'(LAT - 1), "latency");
            chk(dq, {1'h0, sh[w]}, "data");
            chk(8'({rng, lvl}), 8'(sh[o]), "oper");
            chk(8'(busy), 8'h01, "busy");
        end
        else chk(8'(oe), 8'h00, "foreign");
        @(negedge core_clk_in);
        chk(dq, dqvref_pkg::DQVREF_DQ_IDLE, "release");
        chk(8'({busy, oe}), 8'h00, "idle");
    endtask : do_read

    initial begin
        core_clk_in = 1'h0;
        forever #2 core_clk_in = ~core_clk_in;
    end
    initial begin
        #100000;
        mismatches++;
        finish_test();
    end
    initial begin
        ce_in = 1'h1;
        do_reset();
        do_read(ADDR, 1'h1, 1'h0);
        for (int i = 0; i < 4; i++) begin
            do_write(corner[i], i[0], i[1], 1'h0);
        end
        repeat (300) begin
            w = 1'($random(seed));
            o = 1'($random(seed));
            lv = 6'($random(seed));
            case (2'($random(seed)))
                2'h0, 2'h1: do_write(lv, 1'($random(seed)), w, o);
                2'h2: do_read(ADDR, w, o);
                default: do_read(6'h0d, w, o);
            endcase
        end
        ce_in = 1'h0;
        u_ctrl.issue(1'h1, 1'h0, ADDR, 8'h05, o, o);
        ce_in = 1'h1;
        do_read(ADDR, o, o);
        do_reset();
        do_read(ADDR, 1'h0, 1'h1);
        finish_test();
    end
endmodule : testbench
`default_nettype wire
